// ---- top_level_irq_enable_pend.sv ----
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
// top-level interrupt enable and pending controller, apb slave
// assumes level source lines synchronous to mclk_i and an apb master
// ***************************************************************
// ***************************************************************
module top_level_irq_enable_pend
   import irq_top_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [16:0] src_level_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic [16:0] cpu_irq_req_o,
   output logic irq_o
);
   // ***************************************************************
   // bus state
   // ***************************************************************
   typedef struct packed {
      logic [31:0] rdata;
      logic rdy;
      logic err;
      logic [16:0] req;
      logic [1:0] mask;
   } bus_state_t;
   bus_state_t s_q, s_d;
   logic [16:0] en_v, pd_v, req_v;
   logic [16:0] en_set, en_clr, pd_set, pd_clr;
   logic [1:0] status_v, events;
   logic irq_w, wr_acc, rd_acc, rd_stat, setup;
   logic [16:0] wbits;
   // one wait state: answer comes in the first access cycle's next edge
   assign setup = psel_i & penable_i & ~s_q.rdy;
   assign wr_acc = setup & pwrite_i;
   assign rd_acc = setup & ~pwrite_i;
   assign wbits = pwdata_i[16:0];
   assign rd_stat = rd_acc & (paddr_i == IRQ_STATUS_OFS);
   // ***************************************************************
   // write strobes per register
   // ***************************************************************
   always_comb begin
      en_set = '0;
      en_clr = '0;
      pd_set = '0;
      pd_clr = '0;
      if (wr_acc && paddr_i == ENABLE_SET_OFS) begin
         en_set = wbits;
      end else if (wr_acc && paddr_i == ENABLE_CLEAR_OFS) begin
         en_clr = wbits;
      end else if (wr_acc && paddr_i == PENDING_SET_OFS) begin
         pd_set = wbits;
      end else if (wr_acc && paddr_i == PENDING_CLEAR_OFS) begin
         pd_clr = wbits;
      end
   end
   // ***************************************************************
   // per-source bits: index equals source bit position
   // ***************************************************************
   for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      src_bit u_bit (
         .mclk_i(mclk_i),
         .rstn_i(rstn_i),
         .en_set_i(en_set[i]),
         .en_clr_i(en_clr[i]),
         .pd_set_i(pd_set[i]),
         .pd_clr_i(pd_clr[i]),
         .level_i(src_level_i[i]),
         .enable_o(en_v[i]),
         .pending_o(pd_v[i]),
         .request_o(req_v[i])
      );
   end
   // ***************************************************************
   // sticky events: any pend set write or live source level, and request rise
   // ***************************************************************
   assign events[STAT_NEW_PEND] = |(pd_set | src_level_i);
   assign events[STAT_REQ_RISE] = |(req_v & ~s_q.req);
   irq_sticky u_sticky (
      .mclk_i(mclk_i),
      .rstn_i(rstn_i),
      .event_i(events),
      .read_clr_i(rd_stat),
      .mask_i(s_q.mask),
      .status_o(status_v),
      .irq_o(irq_w)
   );
   // ***************************************************************
   // apb read mux and state update
   // ***************************************************************
   always_comb begin
      s_d = s_q;
      s_d.rdy = setup;
      s_d.err = 1'b0;
      s_d.req = req_v;
      if (wr_acc && paddr_i == IRQ_MASK_OFS) begin
         s_d.mask = pwdata_i[1:0];
      end
      if (setup) begin
         s_d.rdata = 32'h0000_0000;
         if (paddr_i == ENABLE_SET_OFS || paddr_i == ENABLE_CLEAR_OFS) begin
            s_d.rdata[16:0] = pwrite_i ? 17'h0_0000 : en_v;
         end else if (paddr_i == PENDING_SET_OFS) begin
            s_d.rdata[16:0] = pwrite_i ? 17'h0_0000 : pd_v;
         end else if (paddr_i == PENDING_CLEAR_OFS) begin
            s_d.rdata[16:0] = 17'h0_0000;
         end else if (paddr_i == IRQ_STATUS_OFS) begin
            s_d.rdata[1:0] = pwrite_i ? 2'h0 : status_v;
         end else if (paddr_i == IRQ_MASK_OFS) begin
            s_d.rdata[1:0] = pwrite_i ? 2'h0 : s_q.mask;
         end else begin
            s_d.err = 1'b1; // unmapped address
         end
      end
   end
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign prdata_o = s_q.rdata;
   assign pready_o = s_q.rdy;
   assign pslverr_o = s_q.err;
   assign cpu_irq_req_o = s_q.req;
   assign irq_o = irq_w;
   // ***************************************************************
   // checks
   // ***************************************************************
   property p_set_en;
      @(posedge mclk_i) disable iff (!rstn_i)
         en_set[BIT_DEBUG] |=> en_v[BIT_DEBUG];
   endproperty
   a_set_en: assert property (p_set_en) else $error("enable set failed");
   property p_zero_keeps;
      @(posedge mclk_i) disable iff (!rstn_i)
         (wr_acc && paddr_i == ENABLE_SET_OFS && !wbits[BIT_EXT_A] && !en_clr[BIT_EXT_A])
         |=> en_v[BIT_EXT_A] == $past(en_v[BIT_EXT_A]);
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed");
   property p_clr_en;
      @(posedge mclk_i) disable iff (!rstn_i)
         en_clr[BIT_ADC] |=> !en_v[BIT_ADC];
   endproperty
   a_clr_en: assert property (p_clr_en) else $error("enable clear failed");
   property p_pend;
      @(posedge mclk_i) disable iff (!rstn_i)
         pd_set[BIT_MAC_RX] |=> pd_v[BIT_MAC_RX];
   endproperty
   a_pend: assert property (p_pend) else $error("pend set failed");
   property p_level;
      @(posedge mclk_i) disable iff (!rstn_i)
         src_level_i[BIT_SECURITY] |=> pd_v[BIT_SECURITY];
   endproperty
   a_level: assert property (p_level) else $error("level lost against unpend");
   property p_req;
      @(posedge mclk_i) disable iff (!rstn_i)
         ##1 cpu_irq_req_o == $past(en_v & pd_v);
   endproperty
   a_req: assert property (p_req) else $error("request not enable and pending");
   property p_keep_pend;
      @(posedge mclk_i) disable iff (!rstn_i)
         (pd_v[BIT_SLEEP] && !pd_clr[BIT_SLEEP]) |=> pd_v[BIT_SLEEP];
   endproperty
   a_keep_pend: assert property (p_keep_pend) else $error("pending dropped");
   property p_unpend;
      @(posedge mclk_i) disable iff (!rstn_i)
         (pd_clr[BIT_TIMER_ONE] && !src_level_i[BIT_TIMER_ONE] && !pd_set[BIT_TIMER_ONE])
         |=> !pd_v[BIT_TIMER_ONE];
   endproperty
   a_unpend: assert property (p_unpend) else $error("unpend failed");
   sequence s_read_en;
      rd_acc && paddr_i == ENABLE_CLEAR_OFS;
   endsequence
   property p_read;
      @(posedge mclk_i) disable iff (!rstn_i)
         s_read_en |=> pready_o && prdata_o == {15'h0000, $past(en_v)};
   endproperty
   a_read: assert property (p_read) else $error("enable readback wrong");
   property p_reset;
      @(posedge mclk_i) $rose(rstn_i) |-> en_v == ENABLE_RESET && pd_v == PENDING_RESET;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");
   property p_reset_pend;
      @(posedge mclk_i) $rose(rstn_i) |-> pd_v == PENDING_RESET && cpu_irq_req_o == '0;
   endproperty
   a_reset_pend: assert property (p_reset_pend) else $error("pending not clear");
   property p_reset_bus;
      @(posedge mclk_i) $rose(rstn_i) |-> !pready_o && !pslverr_o && !irq_o;
   endproperty
   a_reset_bus: assert property (p_reset_bus) else $error("outputs not idle");
   // ***************************************************************
   // bus handshake checks
   // ***************************************************************
   // a master that holds its request gets exactly one wait state
   sequence s_access;
      psel_i && penable_i && !pready_o;
   endsequence
   sequence s_answer;
      psel_i && penable_i && pready_o;
   endsequence
   property p_one_wait;
      @(posedge mclk_i) disable iff (!rstn_i)
         s_access |=> pready_o;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("answer not after one wait");
   property p_ready_pulse;
      @(posedge mclk_i) disable iff (!rstn_i)
         s_answer |=> !pready_o;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
   property p_err_rdy;
      @(posedge mclk_i) disable iff (!rstn_i)
         pslverr_o |-> pready_o;
   endproperty
   a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
   property p_upper_zero;
      @(posedge mclk_i) disable iff (!rstn_i)
         pready_o |-> prdata_o[31:17] == 15'h0000;
   endproperty
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
   sequence s_read_pend;
      rd_acc && paddr_i == PENDING_SET_OFS;
   endsequence
   property p_read_pend;
      @(posedge mclk_i) disable iff (!rstn_i)
         s_read_pend |=> prdata_o == {15'h0000, $past(pd_v)};
   endproperty
   a_read_pend: assert property (p_read_pend) else $error("pend readback wrong");
   property p_read_set;
      @(posedge mclk_i) disable iff (!rstn_i)
         (rd_acc && paddr_i == ENABLE_SET_OFS) |=> prdata_o == {15'h0000, $past(en_v)};
   endproperty
   a_read_set: assert property (p_read_set) else $error("set readback wrong");
   property p_write_quiet;
      @(posedge mclk_i) disable iff (!rstn_i)
         (setup && pwrite_i) |=> prdata_o == 32'h0000_0000;
   endproperty
   a_write_quiet: assert property (p_write_quiet) else $error("write gave data");
   // an unmapped or mask write must leave every enable alone
   sequence s_stray_wr;
      wr_acc && paddr_i != ENABLE_SET_OFS && paddr_i != ENABLE_CLEAR_OFS
         && paddr_i != PENDING_SET_OFS && paddr_i != PENDING_CLEAR_OFS;
   endsequence
   property p_stray_wr;
      @(posedge mclk_i) disable iff (!rstn_i)
         s_stray_wr |=> en_v == $past(en_v);
   endproperty
   a_stray_wr: assert property (p_stray_wr) else $error("stray write hit enable");
   // ***************************************************************
   // sticky status checks
   // ***************************************************************
   property p_event_sticks;
      @(posedge mclk_i) disable iff (!rstn_i)
         (events != 2'h0) |=> (status_v & $past(events)) == $past(events);
   endproperty
   a_event_sticks: assert property (p_event_sticks) else $error("event lost");
   property p_irq_on;
      @(posedge mclk_i) disable iff (!rstn_i)
         (events & s_q.mask) != 2'h0 |=> irq_o;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("event did not interrupt");
   property p_irq_off;
      @(posedge mclk_i) disable iff (!rstn_i)
         ((status_v | events) & s_q.mask) == 2'h0 |=> !irq_o;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("interrupt without cause");
   property p_read_clears;
      @(posedge mclk_i) disable iff (!rstn_i)
         (rd_stat && events == 2'h0) |=> status_v == 2'h0;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("status read kept bits");
   // ***************************************************************
   // per-source checks
   // ***************************************************************
   // same checks on every bit, so a crossed wire between sources shows up
   for (genvar i = 0; i < NUM_SRC; i++) begin : g_chk
      property p_bit_set;
         @(posedge mclk_i) disable iff (!rstn_i)
            (wr_acc && paddr_i == ENABLE_SET_OFS && pwdata_i[i]) |=> en_v[i];
      endproperty
      a_bit_set: assert property (p_bit_set)
         else $error("source enable set failed");
      property p_bit_keep;
         @(posedge mclk_i) disable iff (!rstn_i)
            (wr_acc && paddr_i == ENABLE_SET_OFS && !pwdata_i[i])
            |=> en_v[i] == $past(en_v[i]);
      endproperty
      a_bit_keep: assert property (p_bit_keep)
         else $error("zero set write changed enable");
      property p_bit_clr;
         @(posedge mclk_i) disable iff (!rstn_i)
            (wr_acc && paddr_i == ENABLE_CLEAR_OFS && pwdata_i[i]) |=> !en_v[i];
      endproperty
      a_bit_clr: assert property (p_bit_clr)
         else $error("source enable clear failed");
      property p_bit_clr_keep;
         @(posedge mclk_i) disable iff (!rstn_i)
            (wr_acc && paddr_i == ENABLE_CLEAR_OFS && !pwdata_i[i])
            |=> en_v[i] == $past(en_v[i]);
      endproperty
      a_bit_clr_keep: assert property (p_bit_clr_keep)
         else $error("zero clear write changed enable");
      property p_bit_pend;
         @(posedge mclk_i) disable iff (!rstn_i)
            (wr_acc && paddr_i == PENDING_SET_OFS && pwdata_i[i]) |=> pd_v[i];
      endproperty
      a_bit_pend: assert property (p_bit_pend)
         else $error("source pend failed");
      property p_bit_pend_keep;
         @(posedge mclk_i) disable iff (!rstn_i)
            (!pd_set[i] && !pd_clr[i] && !src_level_i[i])
            |=> pd_v[i] == $past(pd_v[i]);
      endproperty
      a_bit_pend_keep: assert property (p_bit_pend_keep)
         else $error("pending changed without cause");
      property p_bit_unpend;
         @(posedge mclk_i) disable iff (!rstn_i)
            (wr_acc && paddr_i == PENDING_CLEAR_OFS && pwdata_i[i] && !src_level_i[i])
            |=> !pd_v[i];
      endproperty
      a_bit_unpend: assert property (p_bit_unpend)
         else $error("source unpend failed");
      property p_bit_level;
         @(posedge mclk_i) disable iff (!rstn_i)
            src_level_i[i] |=> pd_v[i];
      endproperty
      a_bit_level: assert property (p_bit_level)
         else $error("live level not pending");
      property p_bit_req;
         @(posedge mclk_i) disable iff (!rstn_i)
            ##1 cpu_irq_req_o[i] == $past(en_v[i] && pd_v[i]);
      endproperty
      a_bit_req: assert property (p_bit_req)
         else $error("source request wrong");
   end
endmodule

// ---- irq_top_pkg.sv ----
// package for the top-level interrupt enable and pending block
// assumes a 32-bit apb slave and a single 20 MHz clock
package irq_top_pkg;
   localparam int NUM_SRC = 17;
   localparam logic [11:0] ENABLE_SET_OFS = 12'h100;
   localparam logic [11:0] ENABLE_CLEAR_OFS = 12'h180;
   localparam logic [11:0] PENDING_SET_OFS = 12'h200;
   localparam logic [11:0] PENDING_CLEAR_OFS = 12'h280;
   localparam logic [11:0] IRQ_STATUS_OFS = 12'h400;
   localparam logic [11:0] IRQ_MASK_OFS = 12'h404;
   localparam logic [16:0] ENABLE_RESET = 17'h0_0000;
   localparam logic [16:0] PENDING_RESET = 17'h0_0000;
   localparam logic [1:0] STAT_BITS = 2'h2;
   localparam int STAT_NEW_PEND = 0;
   localparam int STAT_REQ_RISE = 1;
   localparam int BIT_DEBUG = 16;
   localparam int BIT_EXT_D = 15;
   localparam int BIT_EXT_A = 12;
   localparam int BIT_ADC = 11;
   localparam int BIT_MAC_RX = 10;
   localparam int BIT_MAC_TMR = 8;
   localparam int BIT_SECURITY = 7;
   localparam int BIT_SERIAL_ONE = 5;
   localparam int BIT_SLEEP = 4;
   localparam int BIT_TIMER_ONE = 0;
endpackage

// ---- src_bit.sv ----
`timescale 1ns/1ps
// one source's enable and pending flip-flops
// assumes decoded one-cycle write strobes from the register slave
module src_bit
   import irq_top_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic en_set_i,
   input wire logic en_clr_i,
   input wire logic pd_set_i,
   input wire logic pd_clr_i,
   input wire logic level_i,
   output logic enable_o,
   output logic pending_o,
   output logic request_o
);
   typedef struct packed {
      logic en;
      logic pd;
   } bit_state_t;
   bit_state_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      if (en_set_i) begin
         s_d.en = 1'b1;
      end else if (en_clr_i) begin
         s_d.en = 1'b0;
      end
      // level input wins over an unpend, so a live source is never lost
      if (pd_clr_i) begin
         s_d.pd = 1'b0;
      end
      if (pd_set_i || level_i) begin
         s_d.pd = 1'b1;
      end
   end
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign enable_o = s_q.en;
   assign pending_o = s_q.pd;
   assign request_o = s_q.en & s_q.pd;
endmodule

// ---- irq_sticky.sv ----
`timescale 1ns/1ps
// sticky event status with mask, cleared by reading
// assumes read_clr_i is a one-cycle pulse at the apb read edge
module irq_sticky
   import irq_top_pkg::*;
(
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [1:0] event_i,
   input wire logic read_clr_i,
   input wire logic [1:0] mask_i,
   output logic [1:0] status_o,
   output logic irq_o
);
   typedef struct packed {
      logic [1:0] st;
      logic irq;
   } sticky_state_t;
   sticky_state_t s_q, s_d;
   always_comb begin
      s_d = s_q;
      // set beats the read clear in the same cycle
      if (read_clr_i) begin
         s_d.st = 2'h0;
      end
      s_d.st = s_d.st | event_i;
      s_d.irq = |(s_d.st & mask_i);
   end
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign status_o = s_q.st;
   assign irq_o = s_q.irq;
endmodule

// ---- periph_src_model.sv ----
`timescale 1ns/1ps
// model of the second-level peripheral flags that feed the top level
// assumes raise/drop pulses from the bench, synchronous to mclk_i
module periph_src_model (
   input wire logic mclk_i,
   input wire logic rstn_i,
   input wire logic [16:0] raise_i,
   input wire logic [16:0] drop_i,
   output logic [16:0] level_o
);
   // a flag holds high until cleared at its own level, never pulses
   always_ff @(posedge mclk_i) begin
      if (!rstn_i) begin
         level_o <= 17'h0_0000;
      end else begin
         level_o <= (level_o | raise_i) & ~drop_i;
      end
   end
endmodule

// ---- top_level_irq_enable_pend_tb.sv ----
`timescale 1ns/1ps
// self-checking bench for the top-level interrupt enable and pending block
// assumes an apb slave that answers after its own wait states
module top_level_irq_enable_pend_tb;
   import irq_top_pkg::*;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [16:0] raise = 17'h0_0000;
   logic [16:0] drop = 17'h0_0000;
   logic [16:0] level, req;
   logic [31:0] prdata, rd, exp;
   logic pready, pslverr, irq, err;
   int miscompares = 0;
   int n_compared = 0;
   always #25 mclk = ~mclk;
   top_level_irq_enable_pend top_level_irq_enable_pend_i (.mclk_i(mclk), .rstn_i(rstn),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .src_level_i(level), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .cpu_irq_req_o(req), .irq_o(irq));
   periph_src_model periph_src_model_i (.mclk_i(mclk), .rstn_i(rstn), .raise_i(raise),
      .drop_i(drop), .level_o(level));
   // ***************************************************************
   // checks and bus tasks
   // ***************************************************************
   task automatic conclude();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic chk_bit(input string what, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %b seen %b", what, e, g);
      end
   endtask
   // values read right after the edge are the ones sampled at it
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         chk_bit("pready", 1'b1, pready);
         conclude();
      end
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk_word("prdata", e, rd);
      chk_bit("pslverr", 1'b0, err);
   endtask
   task automatic reset_chk();
      rstn <= 1'b0;
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      rd_chk(ENABLE_SET_OFS, 32'h0000_0000);
      rd_chk(ENABLE_CLEAR_OFS, 32'h0000_0000);
      rd_chk(PENDING_SET_OFS, 32'h0000_0000);
      chk_word("irq_req", 32'h0000_0000, {15'h0000, req});
      $display("test reset done");
   endtask
   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      reset_chk();
      // walk one source at a time, junk in the unused upper bits
      exp = 32'h0000_0000;
      for (int i = 0; i < NUM_SRC; i++) begin
         apb(1'b1, ENABLE_SET_OFS, 32'hFFFE_0000 | (32'h0000_0001 << i));
         exp = exp | (32'h0000_0001 << i);
         rd_chk(ENABLE_SET_OFS, exp);
      end
      apb(1'b1, ENABLE_CLEAR_OFS, 32'hFFFE_5555);
      rd_chk(ENABLE_CLEAR_OFS, 32'h0001_AAAA);
      $display("test enable done");
      apb(1'b1, PENDING_SET_OFS, 32'hFFFE_04F1);
      rd_chk(PENDING_SET_OFS, 32'h0000_04F1);
      chk_word("irq_req", 32'h0000_00A0, {15'h0000, req});
      chk_bit("irq", 1'b0, irq);
      apb(1'b1, IRQ_MASK_OFS, 32'h0000_0003);
      rd_chk(IRQ_MASK_OFS, 32'h0000_0003);
      rd_chk(PENDING_SET_OFS, 32'h0000_04F1);
      chk_bit("irq", 1'b1, irq);
      rd_chk(IRQ_STATUS_OFS, 32'h0000_0003);
      rd_chk(IRQ_STATUS_OFS, 32'h0000_0000);
      chk_bit("irq", 1'b0, irq);
      apb(1'b1, PENDING_CLEAR_OFS, 32'h0000_0021);
      rd_chk(PENDING_SET_OFS, 32'h0000_04D0);
      rd_chk(PENDING_CLEAR_OFS, 32'h0000_0000);
      chk_word("irq_req", 32'h0000_0080, {15'h0000, req});
      $display("test pending done");
      // a level still high must win over clear-pending
      raise <= 17'h0_0280;
      @(posedge mclk);
      raise <= 17'h0_0000;
      apb(1'b1, PENDING_CLEAR_OFS, 32'h0001_FFFF);
      rd_chk(PENDING_SET_OFS, 32'h0000_0280);
      chk_word("irq_req", 32'h0000_0280, {15'h0000, req});
      drop <= 17'h0_0280;
      @(posedge mclk);
      drop <= 17'h0_0000;
      apb(1'b1, PENDING_CLEAR_OFS, 32'h0000_0280);
      rd_chk(PENDING_SET_OFS, 32'h0000_0000);
      chk_word("irq_req", 32'h0000_0000, {15'h0000, req});
      $display("test level done");
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk_bit("pslverr", 1'b1, err);
      chk_word("prdata", 32'h0000_0000, rd);
      apb(1'b1, 12'h008, 32'hFFFF_FFFF);
      chk_bit("pslverr", 1'b1, err);
      rd_chk(ENABLE_SET_OFS, 32'h0001_AAAA);
      apb(1'b1, ENABLE_CLEAR_OFS, 32'h0000_0800);
      rd_chk(ENABLE_SET_OFS, 32'h0001_A2AA);
      $display("test unmapped done");
      reset_chk();
      conclude();
   end
endmodule
